// >>> rtl/standby_keepalive_pkg.sv
// Constants and carrier types for the standby keep-alive gating block
package standby_keepalive_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int NUM_CH = 16;
  localparam int NUM_SETUP = 8;
  localparam int SETUP_W = 3;
  localparam int NUM_GPO = 4;
  localparam int NUM_PIN = 8;
  localparam int BURN_W = 2;
  localparam int EXC_W = 3;
  localparam int PINSEL_W = 4;
  localparam int CTRL_W = 16;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 16'h00EE;

  // Control word bit positions
  localparam int KEEP_DIAG_BIT = 7;
  localparam int KEEP_GPO_BIT = 6;
  localparam int KEEP_SW_BIT = 5;
  localparam int KEEP_BIAS_BIT = 3;
  localparam int KEEP_EXC_BIT = 2;
  localparam int KEEP_BURN_BIT = 1;

  // Status word bit positions
  localparam int ST_STANDBY_BIT = 0;
  localparam int ST_DIAG_BIT = 1;
  localparam int ST_OSC_BIT = 2;
  localparam int ST_SW_BIT = 3;
  localparam int ST_BIAS_BIT = 4;
  localparam int ST_EXC_BIT = 5;
  localparam int ST_BURN_BIT = 6;
  localparam int ST_GPO_BIT = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic diag_enabled;
    logic voltage_monitor_enabled;
    logic internal_osc_selected;
    logic [NUM_GPO-1:0] gpo_enabled;
    logic [NUM_PIN-1:0] bias_pin_enable;
    logic [NUM_CH-1:0][SETUP_W-1:0] chan_setup;
    logic [NUM_CH-1:0] channel_switch_setting;
    logic [NUM_CH-1:0][PINSEL_W-1:0] excitation_a_pin_select;
    logic [NUM_CH-1:0][PINSEL_W-1:0] excitation_b_pin_select;
    logic [NUM_SETUP-1:0][BURN_W-1:0] setup_burnout;
    logic [NUM_SETUP-1:0][EXC_W-1:0] setup_excitation_a_value;
    logic [NUM_SETUP-1:0][EXC_W-1:0] setup_excitation_b_value;
  } normal_cfg_t;

  typedef struct packed {
    logic diag_run;
    logic osc_keep;
    logic [NUM_GPO-1:0] gpo_drive_en;
    logic [NUM_PIN-1:0] bias_pin_drive;
    logic [NUM_CH-1:0] chan_switch_close;
    logic [NUM_CH-1:0][BURN_W-1:0] chan_burnout;
    logic [NUM_CH-1:0][EXC_W-1:0] chan_exc_a_value;
    logic [NUM_CH-1:0][EXC_W-1:0] chan_exc_b_value;
    logic [NUM_CH-1:0][PINSEL_W-1:0] chan_exc_a_pin;
    logic [NUM_CH-1:0][PINSEL_W-1:0] chan_exc_b_pin;
  } aux_power_t;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [CTRL_W-1:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    aux_power_t aux;
  } state_t;

endpackage : standby_keepalive_pkg

// >>> rtl/standby_keepalive_gating.sv
// Standby keep-alive gating of auxiliary sensor functions with AXI4-Lite registers
// Behaviour
// [R1] Diagnostics keep bit clear: diagnostics off in standby; set: enabled diagnostics stay
// [R2] Bit 6 set keeps enabled outputs alive in standby; clear disables them
// [R3] Bit 5 clear: low-side power switch disabled in standby
// [R4] Bit 5 set: per-channel switch setting decides the switch in standby
// [R5] Bit 1 clear: open-wire current sources off in standby
// [R6] Bit 1 set: each setup's open-wire setting decides current in standby
// [R7] Bit 3 clear: bias voltage generator disabled in standby
// [R8] Bit 3 set: per-pin bias enables choose which pins keep bias
// [R9] Bit 2 clear: excitation current sources disabled in standby
// [R10] Bit 2 set: setup excitation fields decide excitation in standby
// [R11] Kept excitation still routed to the per-channel selected pins in standby
// [R12] Diagnostics keep bit at bit 7, resets to zero, read/write
// [R13] Kept diagnostics hold oscillator alive if voltage monitor and internal clock
// [R14] Leaving standby restores every function to its normal settings
// [R15] All keep bits reset to zero, forcing functions off in standby
`timescale 1ns/1ps
`default_nettype none

module standby_keepalive_gating
  import standby_keepalive_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire axil_req_t axi_req,
  output axil_rsp_t axi_rsp,
  input wire logic in_standby,
  input wire normal_cfg_t cfg,
  output aux_power_t aux
);

  // ****************************************************************
  // State
  // ****************************************************************
  state_t st_r;
  state_t st_nxt;
  logic aw_take;
  logic w_take;
  logic ar_take;

  assign axi_rsp.awready = ce & ~st_r.aw_got & ~st_r.bvalid;
  assign axi_rsp.wready = ce & ~st_r.w_got & ~st_r.bvalid;
  assign axi_rsp.arready = ce & ~st_r.rvalid;
  assign axi_rsp.bvalid = st_r.bvalid;
  assign axi_rsp.bresp = st_r.bresp;
  assign axi_rsp.rvalid = st_r.rvalid;
  assign axi_rsp.rdata = st_r.rdata;
  assign axi_rsp.rresp = st_r.rresp;
  assign aux = st_r.aux;

  assign aw_take = axi_req.awvalid & axi_rsp.awready;
  assign w_take = axi_req.wvalid & axi_rsp.wready;
  assign ar_take = axi_req.arvalid & axi_rsp.arready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [SETUP_W-1:0] sel;
    logic [CTRL_W-1:0] lane;
    logic [31:0] status;
    logic awake;
    logic pass_diag;
    logic pass_gpo;
    logic pass_sw;
    logic pass_bias;
    logic pass_exc;
    logic pass_burn;
    sel = '0;
    lane = '0;
    status = '0;
    st_nxt = st_r;
    awake = ~in_standby;
    // Keep bits, awake passes everything
    pass_diag = awake | st_r.ctrl[KEEP_DIAG_BIT];
    pass_gpo = awake | st_r.ctrl[KEEP_GPO_BIT];
    pass_sw = awake | st_r.ctrl[KEEP_SW_BIT];
    pass_bias = awake | st_r.ctrl[KEEP_BIAS_BIT];
    pass_exc = awake | st_r.ctrl[KEEP_EXC_BIT];
    pass_burn = awake | st_r.ctrl[KEEP_BURN_BIT];

    // Write channel capture
    if (aw_take) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end
    if (w_take) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = axi_req.wdata[CTRL_W-1:0];
      st_nxt.w_strb = axi_req.wstrb[1:0];
    end
    // [R12] Control word write
    if (ce && st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      lane = {{8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}} & CTRL_WMASK;
      if (st_r.aw_addr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
        st_nxt.ctrl = (st_r.ctrl & ~lane) | (st_r.w_data & lane);
      end else if (st_r.aw_addr[ADDR_W-1:2] != STATUS_OFFSET[ADDR_W-1:2]) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    if (ce && st_r.bvalid && axi_req.bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Status word from the standby input and gated outputs
    status[ST_STANDBY_BIT] = in_standby;
    status[ST_DIAG_BIT] = st_r.aux.diag_run;
    status[ST_OSC_BIT] = st_r.aux.osc_keep;
    status[ST_SW_BIT] = |st_r.aux.chan_switch_close;
    status[ST_BIAS_BIT] = |st_r.aux.bias_pin_drive;
    status[ST_EXC_BIT] = |{st_r.aux.chan_exc_a_value, st_r.aux.chan_exc_b_value};
    status[ST_BURN_BIT] = |st_r.aux.chan_burnout;
    status[ST_GPO_BIT] = |st_r.aux.gpo_drive_en;

    // Read channel
    if (ar_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = '0;
      if (axi_req.araddr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
        st_nxt.rdata = {16'h0000, st_r.ctrl};
      end else if (axi_req.araddr[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]) begin
        st_nxt.rdata = status;
      end else begin
        st_nxt.rresp = RESP_SLVERR;
      end
    end
    if (ce && st_r.rvalid && axi_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // [R1] Diagnostics gating
    st_nxt.aux.diag_run = cfg.diag_enabled & pass_diag;
    // [R13] Oscillator hold request
    st_nxt.aux.osc_keep = in_standby & st_r.ctrl[KEEP_DIAG_BIT]
                          & cfg.voltage_monitor_enabled & cfg.internal_osc_selected;
    // [R2] Output gating
    st_nxt.aux.gpo_drive_en = cfg.gpo_enabled & {NUM_GPO{pass_gpo}};
    // [R7] [R8] Bias pin gating
    st_nxt.aux.bias_pin_drive = cfg.bias_pin_enable & {NUM_PIN{pass_bias}};
    // [R14] Per-channel gating follows settings when awake
    for (int c = 0; c < NUM_CH; c++) begin
      sel = cfg.chan_setup[c];
      // [R3] [R4] Power switch per channel
      st_nxt.aux.chan_switch_close[c] = cfg.channel_switch_setting[c] & pass_sw;
      // [R5] [R6] Open-wire current per setup
      st_nxt.aux.chan_burnout[c] = pass_burn ? cfg.setup_burnout[sel] : '0;
      // [R9] [R10] Excitation magnitude per setup
      st_nxt.aux.chan_exc_a_value[c] = pass_exc ? cfg.setup_excitation_a_value[sel] : '0;
      st_nxt.aux.chan_exc_b_value[c] = pass_exc ? cfg.setup_excitation_b_value[sel] : '0;
      // [R11] Excitation routing
      st_nxt.aux.chan_exc_a_pin[c] = pass_exc ? cfg.excitation_a_pin_select[c] : '0;
      st_nxt.aux.chan_exc_b_pin[c] = pass_exc ? cfg.excitation_b_pin_select[c] : '0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // [R15] Keep bits cleared by reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_standby_tick;
    ce && in_standby;
  endsequence

  sequence s_wake;
    s_standby_tick ##1 (ce && !in_standby);
  endsequence

  a_diag_forced_off: assert property ( // [R1]
    s_standby_tick and !st_r.ctrl[KEEP_DIAG_BIT] |=> !aux.diag_run
  ) else $error("diagnostics running in standby without keep bit");

  a_gpo_gated: assert property ( // [R2]
    s_standby_tick |=> aux.gpo_drive_en ==
      ($past(cfg.gpo_enabled) & {NUM_GPO{$past(st_r.ctrl[KEEP_GPO_BIT])}})
  ) else $error("output enables wrong in standby");

  a_switch_forced_off: assert property ( // [R3]
    s_standby_tick and !st_r.ctrl[KEEP_SW_BIT] |=> aux.chan_switch_close == '0
  ) else $error("power switch closed in standby without keep bit");

  a_switch_follows: assert property ( // [R4]
    s_standby_tick and st_r.ctrl[KEEP_SW_BIT] |=>
      aux.chan_switch_close == $past(cfg.channel_switch_setting)
  ) else $error("power switch ignores channel setting in standby");

  a_burnout_forced_off: assert property ( // [R5]
    s_standby_tick and !st_r.ctrl[KEEP_BURN_BIT] |=> aux.chan_burnout == '0
  ) else $error("open-wire current on in standby without keep bit");

  a_burnout_follows: assert property ( // [R6]
    s_standby_tick and st_r.ctrl[KEEP_BURN_BIT] |=>
      aux.chan_burnout[0] == $past(cfg.setup_burnout[cfg.chan_setup[0]])
  ) else $error("open-wire current ignores setup in standby");

  a_bias_forced_off: assert property ( // [R7]
    s_standby_tick and !st_r.ctrl[KEEP_BIAS_BIT] |=> aux.bias_pin_drive == '0
  ) else $error("bias on in standby without keep bit");

  a_bias_follows: assert property ( // [R8]
    s_standby_tick and st_r.ctrl[KEEP_BIAS_BIT] |=>
      aux.bias_pin_drive == $past(cfg.bias_pin_enable)
  ) else $error("bias pins ignore enables in standby");

  a_exc_forced_off: assert property ( // [R9]
    s_standby_tick and !st_r.ctrl[KEEP_EXC_BIT] |=>
      (aux.chan_exc_a_value == '0) && (aux.chan_exc_b_value == '0)
  ) else $error("excitation on in standby without keep bit");

  a_exc_follows: assert property ( // [R10]
    s_standby_tick and st_r.ctrl[KEEP_EXC_BIT] |=>
      aux.chan_exc_b_value[1] == $past(cfg.setup_excitation_b_value[cfg.chan_setup[1]])
  ) else $error("excitation ignores setup in standby");

  a_exc_routed: assert property ( // [R11]
    s_standby_tick and st_r.ctrl[KEEP_EXC_BIT] |=>
      aux.chan_exc_a_pin == $past(cfg.excitation_a_pin_select)
  ) else $error("excitation routing lost in standby");

  a_osc_hold: assert property ( // [R13]
    ce |=> aux.osc_keep == ($past(in_standby) && $past(st_r.ctrl[KEEP_DIAG_BIT])
      && $past(cfg.voltage_monitor_enabled) && $past(cfg.internal_osc_selected))
  ) else $error("oscillator hold request wrong");

  a_wake_restore: assert property ( // [R14]
    s_wake |=> (aux.diag_run == $past(cfg.diag_enabled))
      && (aux.chan_switch_close == $past(cfg.channel_switch_setting))
  ) else $error("function not restored after leaving standby");

  a_reset_keepalive: assert property ( // [R15]
    $past(reset) |-> st_r.ctrl == CTRL_RESET
  ) else $error("keep bits not cleared by reset");

  // ****************************************************************
  // Register bus, standby and awake checks
  // ****************************************************************
  sequence s_awake_tick;
    ce && !in_standby;
  endsequence

  sequence s_write_commit;
    ce && st_r.aw_got && st_r.w_got && !st_r.bvalid;
  endsequence

  sequence s_both_taken;
    (aw_take && w_take) ##1 ce;
  endsequence

  a_diag_follows: assert property ( // [R1]
    s_standby_tick and st_r.ctrl[KEEP_DIAG_BIT] |=> aux.diag_run == $past(cfg.diag_enabled)
  ) else $error("diagnostics stopped in standby with keep bit");

  a_gpo_forced_off: assert property ( // [R2]
    s_standby_tick and !st_r.ctrl[KEEP_GPO_BIT] |=> aux.gpo_drive_en == '0
  ) else $error("outputs driven in standby without keep bit");

  a_exc_pin_off: assert property ( // [R9]
    s_standby_tick and !st_r.ctrl[KEEP_EXC_BIT] |=>
      (aux.chan_exc_a_pin == '0) && (aux.chan_exc_b_pin == '0)
  ) else $error("excitation routed in standby without keep bit");

  a_exc_a_follows: assert property ( // [R10]
    s_standby_tick and st_r.ctrl[KEEP_EXC_BIT] |=>
      aux.chan_exc_a_value[2] == $past(cfg.setup_excitation_a_value[cfg.chan_setup[2]])
  ) else $error("first excitation ignores setup in standby");

  a_exc_b_routed: assert property ( // [R11]
    s_standby_tick and st_r.ctrl[KEEP_EXC_BIT] |=>
      aux.chan_exc_b_pin == $past(cfg.excitation_b_pin_select)
  ) else $error("second excitation routing lost in standby");

  a_osc_awake_off: assert property ( // [R13]
    s_awake_tick |=> !aux.osc_keep
  ) else $error("oscillator hold requested while awake");

  a_wake_gpo: assert property ( // [R14]
    s_awake_tick |=> aux.gpo_drive_en == $past(cfg.gpo_enabled)
  ) else $error("outputs not following settings while awake");

  a_wake_bias: assert property ( // [R14]
    s_awake_tick |=> aux.bias_pin_drive == $past(cfg.bias_pin_enable)
  ) else $error("bias not following settings while awake");

  a_wake_burnout: assert property ( // [R14]
    s_awake_tick |=> aux.chan_burnout[15] == $past(cfg.setup_burnout[cfg.chan_setup[15]])
  ) else $error("open-wire current not following setup while awake");

  a_wake_excite: assert property ( // [R14]
    s_awake_tick |=> (aux.chan_exc_a_pin == $past(cfg.excitation_a_pin_select))
      && (aux.chan_exc_b_value[3] == $past(cfg.setup_excitation_b_value[cfg.chan_setup[3]]))
  ) else $error("excitation not following settings while awake");

  a_reset_outputs: assert property ( // [R15]
    $past(reset) |-> aux == '0
  ) else $error("outputs not cleared by reset");

  a_ctrl_reserved: assert property ( // [R12]
    (st_r.ctrl & ~CTRL_WMASK) == '0
  ) else $error("reserved control bits set");

  a_ctrl_write: assert property ( // [R12]
    s_write_commit and st_r.w_strb[0]
      and (st_r.aw_addr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2])
      |=> st_r.ctrl[KEEP_DIAG_BIT] == $past(st_r.w_data[KEEP_DIAG_BIT])
  ) else $error("diagnostics keep bit not written");

  a_ctrl_hold: assert property ( // [R12]
    !(st_r.aw_got && st_r.w_got && !st_r.bvalid) |=> $stable(st_r.ctrl)
  ) else $error("control word changed without a write");

  a_ce_freeze: assert property ( // [R12]
    !ce |=> $stable(st_r.ctrl) && $stable(aux)
  ) else $error("state moved while clock enable low");

  a_write_answer: assert property ( // [R12]
    s_both_taken |=> axi_rsp.bvalid
  ) else $error("write response late");

  a_write_refused: assert property ( // [R12]
    st_r.bvalid |-> !axi_rsp.awready && !axi_rsp.wready
  ) else $error("write accepted while response pending");

  a_write_slverr: assert property ( // [R12]
    s_write_commit and (st_r.aw_addr[ADDR_W-1:2] != CTRL_OFFSET[ADDR_W-1:2])
      and (st_r.aw_addr[ADDR_W-1:2] != STATUS_OFFSET[ADDR_W-1:2])
      |=> axi_rsp.bresp == RESP_SLVERR
  ) else $error("unmapped write not refused");

  a_bvalid_drop: assert property ( // [R12]
    ce && axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid
  ) else $error("write response not retired");

  a_read_answer: assert property ( // [R12]
    ar_take |=> axi_rsp.rvalid
  ) else $error("read data late");

  a_read_refused: assert property ( // [R12]
    axi_rsp.rvalid |-> !axi_rsp.arready
  ) else $error("read accepted while data pending");

  a_rvalid_drop: assert property ( // [R12]
    ce && axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid
  ) else $error("read data not retired");

endmodule : standby_keepalive_gating

`default_nettype wire

// >>> tb/standby_keepalive_gating_tb.sv
// Self-checking bench for the standby keep-alive gating block
`timescale 1ns/1ps
`default_nettype none

module standby_keepalive_gating_tb
  import standby_keepalive_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic in_standby = 1'b0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  normal_cfg_t cfg;
  aux_power_t aux;
  int failures = 0;
  int checked = 0;

  always #4 core_clk = ~core_clk;

  standby_keepalive_gating i_dut (.core_clk(core_clk), .reset(reset), .ce(ce), .axi_req(req),
    .axi_rsp(rsp), .in_standby(in_standby), .cfg(cfg), .aux(aux));

  // ****************************************************************
  // Expected outputs
  // ****************************************************************
  function automatic aux_power_t model(logic [15:0] k, logic s, normal_cfg_t c);
    aux_power_t e;
    e = '0;
    e.diag_run = c.diag_enabled & (!s | k[KEEP_DIAG_BIT]);
    e.osc_keep = s & k[KEEP_DIAG_BIT] & c.voltage_monitor_enabled & c.internal_osc_selected;
    if (!s || k[KEEP_GPO_BIT]) e.gpo_drive_en = c.gpo_enabled;
    if (!s || k[KEEP_BIAS_BIT]) e.bias_pin_drive = c.bias_pin_enable;
    if (!s || k[KEEP_SW_BIT]) e.chan_switch_close = c.channel_switch_setting;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (!s || k[KEEP_BURN_BIT]) e.chan_burnout[ch] = c.setup_burnout[c.chan_setup[ch]];
      if (!s || k[KEEP_EXC_BIT]) begin
        e.chan_exc_a_value[ch] = c.setup_excitation_a_value[c.chan_setup[ch]];
        e.chan_exc_b_value[ch] = c.setup_excitation_b_value[c.chan_setup[ch]];
        e.chan_exc_a_pin[ch] = c.excitation_a_pin_select[ch];
        e.chan_exc_b_pin[ch] = c.excitation_b_pin_select[ch];
      end
    end
    return e;
  endfunction : model

  // ****************************************************************
  // Report and compare
  // ****************************************************************
  task automatic finish_test();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_aux(input aux_power_t got, input aux_power_t exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: aux got %h expected %h", $time, got, exp);
    end
  endtask : cmp_aux

  task automatic hang();
    failures++;
    $display("Error at %0t: bus wait ran out", $time);
    finish_test();
  endtask : hang

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic hs_aw, hs_w, hs_b, done;
    done = 1'b0;
    n = 0;
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!done && n < 40) begin
      @(negedge core_clk);
      hs_aw = req.awvalid && rsp.awready;
      hs_w = req.wvalid && rsp.wready;
      hs_b = req.bready && rsp.bvalid;
      if (hs_b) cmp_word({30'h0, rsp.bresp}, {30'h0, er}, "bresp");
      @(posedge core_clk);
      if (hs_aw) req.awvalid <= 1'b0;
      if (hs_w) req.wvalid <= 1'b0;
      if (hs_b) begin
        req.bready <= 1'b0;
        done = 1'b1;
      end
      n++;
    end
    if (!done) hang();
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic hs_ar, hs_r, done;
    done = 1'b0;
    n = 0;
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!done && n < 40) begin
      @(negedge core_clk);
      hs_ar = req.arvalid && rsp.arready;
      hs_r = req.rready && rsp.rvalid;
      if (hs_r) cmp_word(rsp.rdata, ed, "rdata");
      if (hs_r) cmp_word({30'h0, rsp.rresp}, {30'h0, er}, "rresp");
      @(posedge core_clk);
      if (hs_ar) req.arvalid <= 1'b0;
      if (hs_r) begin
        req.rready <= 1'b0;
        done = 1'b1;
      end
      n++;
    end
    if (!done) hang();
  endtask : axi_read

  // Write keep bits, set standby, wait past the output latency
  task automatic go(input logic [15:0] k, input logic s);
    axi_write(CTRL_OFFSET, {16'h0, k}, RESP_OKAY);
    @(posedge core_clk);
    in_standby <= s;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : go

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    axi_read(CTRL_OFFSET, 32'h0, RESP_OKAY);
    go(16'h0000, 1'b1);
    cmp_aux(aux, model(16'h0000, 1'b1, cfg));
    axi_read(STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
    axi_write(12'h010, 32'h0000_00FF, RESP_SLVERR);
    axi_read(12'h010, 32'h0, RESP_SLVERR);
    axi_read(CTRL_OFFSET, 32'h0, RESP_OKAY);
  endtask : t_reset

  task automatic t_bits();
    logic [7:0] tbl [7];
    tbl = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'hEE};
    for (int i = 0; i < 7; i++) begin
      go({8'h00, tbl[i]}, 1'b1);
      cmp_aux(aux, model({8'h00, tbl[i]}, 1'b1, cfg));
      axi_read(CTRL_OFFSET, {24'h0, tbl[i]}, RESP_OKAY);
    end
  endtask : t_bits

  task automatic t_reserved();
    axi_write(CTRL_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
    axi_read(CTRL_OFFSET, {16'h0, CTRL_WMASK}, RESP_OKAY);
    axi_write(STATUS_OFFSET, 32'h0000_0000, RESP_OKAY);
    axi_read(CTRL_OFFSET, {16'h0, CTRL_WMASK}, RESP_OKAY);
  endtask : t_reserved

  // Clock enable low freezes outputs and drops the readies
  task automatic t_freeze();
    @(posedge core_clk);
    ce <= 1'b0;
    in_standby <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    cmp_aux(aux, model(16'h00EE, 1'b1, cfg));
    cmp_word({29'h0, rsp.awready, rsp.wready, rsp.arready}, 32'h0, "readies");
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    cmp_aux(aux, model(16'h00EE, 1'b0, cfg));
  endtask : t_freeze

  task automatic t_wake();
    go(16'h0000, 1'b1);
    go(16'h0000, 1'b0);
    cmp_aux(aux, model(16'h0000, 1'b0, cfg));
    axi_read(STATUS_OFFSET, 32'h0000_00FA, RESP_OKAY);
    @(posedge core_clk);
    cfg.internal_osc_selected <= 1'b0;
    go(16'h0080, 1'b1);
    cmp_aux(aux, model(16'h0080, 1'b1, cfg));
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    axi_read(CTRL_OFFSET, 32'h0, RESP_OKAY);
    cmp_aux(aux, model(16'h0000, 1'b1, cfg));
  endtask : t_wake

  initial begin
    cfg = '0;
    cfg.diag_enabled = 1'b1;
    cfg.voltage_monitor_enabled = 1'b1;
    cfg.internal_osc_selected = 1'b1;
    cfg.gpo_enabled = 4'hA;
    cfg.bias_pin_enable = 8'h5C;
    cfg.channel_switch_setting = 16'hA5C3;
    for (int c = 0; c < NUM_CH; c++) begin
      cfg.chan_setup[c] = SETUP_W'(c * 3);
      cfg.excitation_a_pin_select[c] = PINSEL_W'(c);
      cfg.excitation_b_pin_select[c] = PINSEL_W'(15 - c);
    end
    for (int s = 0; s < NUM_SETUP; s++) begin
      cfg.setup_burnout[s] = BURN_W'(s);
      cfg.setup_excitation_a_value[s] = EXC_W'(s + 1);
      cfg.setup_excitation_b_value[s] = EXC_W'(7 - s);
    end
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_bits();
    t_reserved();
    t_freeze();
    t_wake();
    finish_test();
  end

endmodule : standby_keepalive_gating_tb

`default_nettype wire
